// ---- hw/modem_link_pkg.sv ----
package modem_link_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD = 9_600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int RESET_PULSE_MS = 5;
  localparam int RESET_PULSE_CYCLES = (CLK_HZ / 1000) * RESET_PULSE_MS;
  localparam int RING_PULSE_CYCLES = BIT_CYCLES * 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;
endpackage

// ---- hw/modem_link_if.sv ----
`timescale 1ns/100ps
interface modem_link_if;
  logic host_power_request;
  logic host_reset_n;
  logic txd;
  logic rxd;
  logic dtr_n;
  logic dsr_n;
  logic rts;
  logic cts;
  logic dcd_n;
  logic ri_n;
  logic in_range_indicator;
  modport modem (
    input host_power_request, host_reset_n, txd, dtr_n, rts,
    output rxd, dsr_n, cts, dcd_n, ri_n, in_range_indicator
  );
  modport host (
    output host_power_request, host_reset_n, txd, dtr_n, rts,
    input rxd, dsr_n, cts, dcd_n, ri_n, in_range_indicator
  );
endinterface

// ---- hw/byte_fifo.sv ----
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- hw/modem_end.sv ----
`timescale 1ns/100ps
// Behaviour
// - power request high means modem runs
// - host drives power request low to stop
// - host drives other lines low when off
// - reset active low, at least 5 ms
// - frames are 8 data, no parity, 1 stop
// - carrier detect low in range, high otherwise
// - in-range indicator mirrors carrier detect line
// - host rts high pauses modem transmission
// - modem cts high throttles host sending
// - ring indicator pulses low on waiting messages
module modem_end #(
  parameter int BIT_CYCLES = modem_link_pkg::BIT_CYCLES,
  parameter int RING_CYCLES = modem_link_pkg::RING_PULSE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  modem_link_if.modem LINK,
  input wire logic IN_RANGE,
  input wire logic MODEM_READY,
  input wire logic MSG_WAITING,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic RUNNING
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  logic [2:0] sync_pwr, sync_rst, sync_txd, sync_rts, sync_dtr;
  logic pwr, rst_n_pin, txd_s, rts_s;
  logic active;
  logic in_range_line;

  // three stage synchronisers, level taken when stages 2 and 3 agree
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      sync_pwr <= 3'h0;
      sync_rst <= 3'h7;
      sync_txd <= 3'h7;
      sync_rts <= 3'h0;
      sync_dtr <= 3'h7;
    end else begin
      sync_pwr <= {sync_pwr[1:0], LINK.host_power_request};
      sync_rst <= {sync_rst[1:0], LINK.host_reset_n};
      sync_txd <= {sync_txd[1:0], LINK.txd};
      sync_rts <= {sync_rts[1:0], LINK.rts};
      sync_dtr <= {sync_dtr[1:0], LINK.dtr_n};
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pwr <= 1'b0;
      rst_n_pin <= 1'b1;
      txd_s <= modem_link_pkg::LINE_IDLE;
      rts_s <= 1'b0;
    end else begin
      if (sync_pwr[2] == sync_pwr[1]) pwr <= sync_pwr[2];
      if (sync_rst[2] == sync_rst[1]) rst_n_pin <= sync_rst[2];
      if (sync_txd[2] == sync_txd[1]) txd_s <= sync_txd[2];
      if (sync_rts[2] == sync_rts[1]) rts_s <= sync_rts[2];
    end
  end

  assign active = pwr && rst_n_pin;
  assign RUNNING = active;

  // one internal line feeds both outputs
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) in_range_line <= 1'b1;
    else in_range_line <= !(active && IN_RANGE);
  end
  assign LINK.dcd_n = in_range_line;
  assign LINK.in_range_indicator = in_range_line;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) LINK.dsr_n <= 1'b1;
    else LINK.dsr_n <= !(active && MODEM_READY);
  end

  // ring: one low pulse per rising edge of message waiting while the modem runs
  logic msg_prev;
  logic [$clog2(RING_CYCLES + 1)-1:0] ring_cnt;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      msg_prev <= 1'b0;
      ring_cnt <= '0;
      LINK.ri_n <= 1'b1;
    end else begin
      msg_prev <= MSG_WAITING;
      if (active && MSG_WAITING && !msg_prev) begin
        ring_cnt <= $bits(ring_cnt)'(RING_CYCLES);
        LINK.ri_n <= 1'b0;
      end else if (ring_cnt != '0) begin
        ring_cnt <= ring_cnt - 1'b1;
        LINK.ri_n <= (ring_cnt == 1);
      end else begin
        LINK.ri_n <= 1'b1;
      end
    end
  end

  // transmitter to host, held off by rts between characters
  typedef enum {TX_IDLE, TX_START, TX_DATA_ST, TX_STOP} tx_state_t;
  tx_state_t tx_state;
  logic [CW-1:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  assign TX_READY = active && tx_state == TX_IDLE && !rts_s;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tx_state <= TX_IDLE;
      tx_cnt <= '0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      LINK.rxd <= modem_link_pkg::LINE_IDLE;
    end else if (!active) begin
      tx_state <= TX_IDLE;
      LINK.rxd <= modem_link_pkg::LINE_IDLE;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          LINK.rxd <= modem_link_pkg::LINE_IDLE;
          if (TX_VALID && TX_READY) begin
            tx_shift <= TX_DATA;
            tx_cnt <= CW'(BIT_CYCLES - 1);
            LINK.rxd <= modem_link_pkg::START_LEVEL;
            tx_state <= TX_START;
          end
        end
        TX_START, TX_DATA_ST: begin
          if (tx_cnt != '0) tx_cnt <= tx_cnt - 1'b1;
          else begin
            tx_cnt <= CW'(BIT_CYCLES - 1);
            if (tx_state == TX_START) begin
              tx_bit <= 3'h0;
              tx_state <= TX_DATA_ST;
              LINK.rxd <= tx_shift[0];
              tx_shift <= tx_shift >> 1;
            end else if (tx_bit == 3'(modem_link_pkg::DATA_BITS - 1)) begin
              LINK.rxd <= modem_link_pkg::STOP_LEVEL;
              tx_state <= TX_STOP;
            end else begin
              tx_bit <= tx_bit + 1'b1;
              LINK.rxd <= tx_shift[0];
              tx_shift <= tx_shift >> 1;
            end
          end
        end
        TX_STOP: begin
          if (tx_cnt != '0) tx_cnt <= tx_cnt - 1'b1;
          else tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // receiver from host into a 16 deep fifo; cts throttles once it is full
  typedef enum {RX_IDLE, RX_START, RX_DATA_ST, RX_STOP} rx_state_t;
  rx_state_t rx_state;
  logic [CW-1:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic fifo_in_valid, fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic [7:0] fifo_out_data;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      fifo_in_valid <= 1'b0;
      fifo_in_data <= 8'h00;
    end else begin
      if (fifo_in_valid && fifo_in_ready) fifo_in_valid <= 1'b0;
      if (!active) rx_state <= RX_IDLE;
      else begin
        unique case (rx_state)
          RX_IDLE: if (txd_s == modem_link_pkg::START_LEVEL) begin
            rx_cnt <= CW'(BIT_CYCLES / 2);
            rx_state <= RX_START;
          end
          RX_START: if (rx_cnt != '0) rx_cnt <= rx_cnt - 1'b1;
          else if (txd_s != modem_link_pkg::START_LEVEL) rx_state <= RX_IDLE;
          else begin
            rx_cnt <= CW'(BIT_CYCLES - 1);
            rx_bit <= 3'h0;
            rx_state <= RX_DATA_ST;
          end
          RX_DATA_ST: if (rx_cnt != '0) rx_cnt <= rx_cnt - 1'b1;
          else begin
            rx_cnt <= CW'(BIT_CYCLES - 1);
            rx_shift <= {txd_s, rx_shift[7:1]};
            rx_bit <= rx_bit + 1'b1;
            if (rx_bit == 3'(modem_link_pkg::DATA_BITS - 1)) rx_state <= RX_STOP;
          end
          RX_STOP: if (rx_cnt != '0) rx_cnt <= rx_cnt - 1'b1;
          else begin
            // bad stop bit drops the character
            // a holding stage that drains on this edge may take the new character
            if (txd_s == modem_link_pkg::STOP_LEVEL && (!fifo_in_valid || fifo_in_ready)) begin
              fifo_in_valid <= 1'b1;
              fifo_in_data <= rx_shift;
            end
            rx_state <= RX_IDLE;
          end
        endcase
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(modem_link_pkg::FIFO_DEPTH)) rx_fifo (
    .clk(CORE_CLK),
    .rst(RESET),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(fifo_out_data)
  );
  assign RX_DATA = fifo_out_data;

  // throttle on a full fifo; the holding stage absorbs the one character already under way
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) LINK.cts <= 1'b0;
    else LINK.cts <= !fifo_in_ready;
  end
  logic unused_dtr;
  assign unused_dtr = sync_dtr[2];
endmodule

// ---- hw/host_end.sv ----
`timescale 1ns/100ps
module host_end #(
  parameter int BIT_CYCLES = modem_link_pkg::BIT_CYCLES,
  parameter int RESET_CYCLES = modem_link_pkg::RESET_PULSE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  modem_link_if.host LINK,
  input wire logic POWER_ON,
  input wire logic RESET_REQ,
  input wire logic HOST_READY,
  input wire logic THROTTLE,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic IN_RANGE,
  output logic MODEM_READY,
  output logic RING,
  output logic RESET_BUSY
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  logic [2:0] s_rxd, s_cts, s_dcd, s_dsr, s_ri;
  logic rxd_s, cts_s;
  logic [$clog2(RESET_CYCLES + 1)-1:0] rst_cnt;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      s_rxd <= 3'h7;
      s_cts <= 3'h0;
      s_dcd <= 3'h7;
      s_dsr <= 3'h7;
      s_ri <= 3'h7;
    end else begin
      s_rxd <= {s_rxd[1:0], LINK.rxd};
      s_cts <= {s_cts[1:0], LINK.cts};
      s_dcd <= {s_dcd[1:0], LINK.dcd_n};
      s_dsr <= {s_dsr[1:0], LINK.dsr_n};
      s_ri <= {s_ri[1:0], LINK.ri_n};
    end
  end
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rxd_s <= 1'b1;
      cts_s <= 1'b0;
      IN_RANGE <= 1'b0;
      MODEM_READY <= 1'b0;
      RING <= 1'b0;
    end else begin
      if (s_rxd[2] == s_rxd[1]) rxd_s <= s_rxd[2];
      if (s_cts[2] == s_cts[1]) cts_s <= s_cts[2];
      if (s_dcd[2] == s_dcd[1]) IN_RANGE <= !s_dcd[2];
      if (s_dsr[2] == s_dsr[1]) MODEM_READY <= !s_dsr[2];
      if (s_ri[2] == s_ri[1]) RING <= !s_ri[2];
    end
  end

  // power line always driven, actively low when off
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) LINK.host_power_request <= 1'b0;
    else LINK.host_power_request <= POWER_ON;
  end

  // reset pulse stretched to the minimum width
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) rst_cnt <= '0;
    else if (RESET_REQ && rst_cnt == '0) rst_cnt <= $bits(rst_cnt)'(RESET_CYCLES);
    else if (rst_cnt != '0) rst_cnt <= rst_cnt - 1'b1;
  end
  assign RESET_BUSY = (rst_cnt != '0);
  // everything low while power is off
  assign LINK.host_reset_n = POWER_ON && !RESET_BUSY;
  assign LINK.dtr_n = POWER_ON ? !HOST_READY : 1'b0;
  assign LINK.rts = POWER_ON && THROTTLE;

  typedef enum {T_IDLE, T_SEND} tx_state_t;
  tx_state_t tx_state;
  logic [CW-1:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [9:0] tx_frame;
  logic txd_line;
  assign TX_READY = POWER_ON && tx_state == T_IDLE && !cts_s;
  assign LINK.txd = POWER_ON ? txd_line : 1'b0;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tx_state <= T_IDLE;
      tx_cnt <= '0;
      tx_bit <= 4'h0;
      tx_frame <= 10'h3ff;
      txd_line <= 1'b1;
    end else begin
      unique case (tx_state)
        T_IDLE: begin
          txd_line <= 1'b1;
          if (TX_VALID && TX_READY) begin
            tx_frame <= {modem_link_pkg::STOP_LEVEL, TX_DATA, modem_link_pkg::START_LEVEL};
            tx_cnt <= '0;
            tx_bit <= 4'h0;
            tx_state <= T_SEND;
          end
        end
        T_SEND: begin
          if (tx_cnt == '0) begin
            txd_line <= tx_frame[0];
            tx_frame <= {1'b1, tx_frame[9:1]};
            tx_cnt <= CW'(BIT_CYCLES - 1);
            tx_bit <= tx_bit + 1'b1;
            if (tx_bit == 4'(modem_link_pkg::DATA_BITS + 2)) begin
              tx_state <= T_IDLE;
            end
          end else begin
            tx_cnt <= tx_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  typedef enum {R_IDLE, R_BITS} rx_state_t;
  rx_state_t rx_state;
  logic [CW-1:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [8:0] rx_shift;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rx_state <= R_IDLE;
      rx_cnt <= '0;
      rx_bit <= 4'h0;
      rx_shift <= 9'h000;
      RX_DATA <= 8'h00;
      RX_VALID <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      unique case (rx_state)
        R_IDLE: if (!rxd_s) begin
          rx_cnt <= CW'(BIT_CYCLES / 2 + BIT_CYCLES);
          rx_bit <= 4'h0;
          rx_state <= R_BITS;
        end
        R_BITS: if (rx_cnt != '0) rx_cnt <= rx_cnt - 1'b1;
        else begin
          rx_cnt <= CW'(BIT_CYCLES - 1);
          rx_shift <= {rxd_s, rx_shift[8:1]};
          rx_bit <= rx_bit + 1'b1;
          if (rx_bit == 4'(modem_link_pkg::DATA_BITS)) begin
            rx_state <= R_IDLE;
            if (rxd_s) begin
              RX_DATA <= rx_shift[8:1];
              RX_VALID <= 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule

// ---- bench/link_assertions.sv ----
`timescale 1ns/100ps
module link_assertions #(
  parameter int BIT_CYCLES = 8,
  parameter int RESET_CYCLES = 50
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic host_power_request,
  input wire logic host_reset_n,
  input wire logic txd,
  input wire logic rxd,
  input wire logic rts,
  input wire logic cts,
  input wire logic dcd_n,
  input wire logic ri_n,
  input wire logic in_range_indicator
);
  localparam int FRAME = 10 * BIT_CYCLES;
  int rpos;
  int tpos;
  int low_cnt;
  logic rq;
  logic tq;
  logic armed;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // counts down from the start bit to the last stop-bit cycle
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rpos <= 0;
      rq <= 1'b1;
    end else begin
      rq <= rxd;
      if (rpos != 0)
        rpos <= rpos - 1;
      else if (rq && !rxd)
        rpos <= FRAME - 1;
    end
  end
  // host holds txd low while off, so no frame is tracked then
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tpos <= 0;
      tq <= 1'b0;
    end else if (!host_power_request) begin
      tpos <= 0;
      tq <= 1'b0;
    end else begin
      tq <= txd;
      if (tpos != 0)
        tpos <= tpos - 1;
      else if (tq && !txd)
        tpos <= FRAME - 1;
    end
  end
  // only pulses begun while powered are timed
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      low_cnt <= 0;
      armed <= 1'b0;
    end else if (host_reset_n) begin
      low_cnt <= 0;
      armed <= 1'b0;
    end else begin
      low_cnt <= low_cnt + 1;
      if (low_cnt == 0 && host_power_request)
        armed <= 1'b1;
    end
  end
  sequence ring_low;
    (!ri_n)[*8];
  endsequence
  property ring_pulse;
    $fell(ri_n) |-> ring_low ##[1:40] ri_n;
  endproperty
  AST_IN_RANGE_LINE_MIRROR: assert property (in_range_indicator == dcd_n)
    else $error("in-range indicator differs from carrier detect");
  AST_RXD_START: assert property (rpos > FRAME - BIT_CYCLES |-> !rxd)
    else $error("rxd start bit not held low");
  AST_RXD_STOP: assert property (rpos != 0 && rpos <= BIT_CYCLES |-> rxd)
    else $error("rxd stop bit not high");
  AST_TXD_START: assert property (tpos > FRAME - BIT_CYCLES |-> !txd)
    else $error("txd start bit not held low");
  AST_TXD_STOP: assert property (tpos != 0 && tpos <= BIT_CYCLES |-> txd)
    else $error("txd stop bit not high");
  AST_RTS_PAUSE: assert property (rts[*8] ##0 (rpos == 0 && rxd) |=> rxd)
    else $error("modem started a character while throttled");
  AST_CTS_PAUSE: assert property (cts[*8] ##0 (tpos == 0 && txd) |=> txd || !host_power_request)
    else $error("host started a character while throttled");
  AST_OFF_LINES_LOW: assert property ((!host_power_request)[*2] |-> !txd && !host_reset_n)
    else $error("host line left high while modem is off");
  AST_RESET_WIDTH: assert property ($rose(host_reset_n) && armed |-> low_cnt >= RESET_CYCLES)
    else $error("reset pulse too short");
  AST_RING_PULSE: assert property (ring_pulse)
    else $error("ring pulse malformed");
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  localparam int RING = 20;
  localparam int RST = 50;
  logic clk, rst, in_range, m_ready, msg, m_txv, m_rxr, h_pwr, h_rreq, h_ready, h_thr, h_txv;
  logic [7:0] m_txd, h_txd, b;
  logic m_txr, m_rxv, running, h_txr, h_rxv, h_inr, h_mrdy, ring, rbusy;
  logic [7:0] m_rxd, h_rxd;
  logic [7:0] eq_m[$], eq_h[$], mq[$], hq[$], wq[$];
  logic [7:0] corner[4] = '{8'h00, 8'hff, 8'h01, 8'h80};
  int miscompares = 0;
  int tests_run = 0;
  int nacc = 0;
  int n;
  modem_link_if modem_link_if_inst();
  wire logic rxd = modem_link_if_inst.rxd;
  wire logic txd = modem_link_if_inst.txd;
  wire logic cts = modem_link_if_inst.cts;
  wire logic ri_n = modem_link_if_inst.ri_n;
  wire logic rstn = modem_link_if_inst.host_reset_n;
  wire logic pwr = modem_link_if_inst.host_power_request;
  wire logic dcd_n = modem_link_if_inst.dcd_n;
  wire logic dsr_n = modem_link_if_inst.dsr_n;
  modem_end #(.BIT_CYCLES(8), .RING_CYCLES(RING)) modem_end_inst (
    .CORE_CLK(clk), .RESET(rst), .LINK(modem_link_if_inst.modem), .IN_RANGE(in_range),
    .MODEM_READY(m_ready), .MSG_WAITING(msg), .TX_DATA(m_txd), .TX_VALID(m_txv), .TX_READY(m_txr),
    .RX_DATA(m_rxd), .RX_VALID(m_rxv), .RX_READY(m_rxr), .RUNNING(running));
  host_end #(.BIT_CYCLES(8), .RESET_CYCLES(RST)) host_end_inst (
    .CORE_CLK(clk), .RESET(rst), .LINK(modem_link_if_inst.host), .POWER_ON(h_pwr), .RESET_REQ(h_rreq),
    .HOST_READY(h_ready), .THROTTLE(h_thr), .TX_DATA(h_txd), .TX_VALID(h_txv), .TX_READY(h_txr),
    .RX_DATA(h_rxd), .RX_VALID(h_rxv), .IN_RANGE(h_inr), .MODEM_READY(h_mrdy), .RING(ring),
    .RESET_BUSY(rbusy));
  link_assertions #(.BIT_CYCLES(8), .RESET_CYCLES(RST)) link_assertions_inst (
    .CORE_CLK(clk), .RESET(rst), .host_power_request(pwr), .host_reset_n(rstn), .txd(txd), .rxd(rxd),
    .rts(modem_link_if_inst.rts), .cts(cts), .dcd_n(dcd_n), .ri_n(ri_n),
    .in_range_indicator(modem_link_if_inst.in_range_indicator));
  function automatic logic [7:0] hi(input logic a);
    return {7'h00, a};
  endfunction
  function automatic logic [7:0] low_n(input logic active);
    return {7'h00, !active};
  endfunction
  // 0 host ready, 1 modem ready, 2 running, 3 cts, 4 ring line, 5 reset line
  function automatic logic pick(input int s);
    return s == 0 ? h_txr : s == 1 ? m_txr : s == 2 ? running : s == 3 ? cts : s == 4 ? ri_n : rstn;
  endfunction
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_for(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && pick(s) !== v; i++)
      @(negedge clk);
    if (pick(s) !== v) begin
      chk("wait bound", hi(v), hi(pick(s)));
      finish_test();
    end
  endtask
  task automatic hsend(input logic [7:0] d);
    @(negedge clk);
    h_txd = d;
    h_txv = 1'b1;
    eq_m.push_back(d);
    wait_for(0, 1'b1, 5000);
    @(negedge clk);
    h_txv = 1'b0;
  endtask
  task automatic msend(input logic [7:0] d);
    @(negedge clk);
    m_txd = d;
    m_txv = 1'b1;
    eq_h.push_back(d);
    wait_for(1, 1'b1, 5000);
    @(negedge clk);
    m_txv = 1'b0;
  endtask
  task automatic cmp_q(input string what, ref logic [7:0] e[$], ref logic [7:0] g[$]);
    chk(what, 8'(e.size()), 8'(g.size()));
    for (int i = 0; i < e.size() && i < g.size(); i++)
      chk(what, e[i], g[i]);
    g.delete();
  endtask
  always @(posedge clk) begin
    if (m_rxv && m_rxr)
      mq.push_back(m_rxd);
    if (h_rxv)
      hq.push_back(h_rxd);
    if (h_txv && h_txr)
      nacc++;
  end
  // samples each bit near its middle, least significant first
  initial forever begin
    @(negedge rxd);
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (8) @(negedge clk);
      b[i] = rxd;
    end
    repeat (8) @(negedge clk);
    if (rxd === 1'b1)
      wq.push_back(b);
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst, in_range, m_ready, msg, m_txv, m_rxr, h_pwr, h_rreq, h_ready, h_thr, h_txv} = 11'h420;
    m_txd = 8'h00;
    h_txd = 8'h00;
    n = $urandom(18121);
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("rxd idle", 8'h01, hi(rxd));
    chk("dsr_n", 8'h01, hi(dsr_n));
    chk("ri_n", 8'h01, hi(ri_n));
    chk("power request", 8'h00, hi(pwr));
    chk("txd off", 8'h00, hi(txd));
    h_pwr = 1'b1;
    wait_for(2, 1'b1, 50);
    chk("power request", 8'h01, hi(pwr));
    for (int k = 0; k < 8; k++) begin
      {in_range, m_ready, h_ready} = 3'(k);
      repeat (10) @(negedge clk);
      chk("dcd_n", low_n(in_range), hi(dcd_n));
      chk("in range indicator", low_n(in_range), hi(modem_link_if_inst.in_range_indicator));
      chk("host in range", hi(in_range), hi(h_inr));
      chk("dsr_n", low_n(m_ready), hi(dsr_n));
      chk("host modem ready", hi(m_ready), hi(h_mrdy));
      chk("dtr_n", low_n(h_ready), hi(modem_link_if_inst.dtr_n));
    end
    m_rxr = 1'b0;
    fork
      for (int k = 0; k < 24; k++)
        hsend(k < 4 ? corner[k] : 8'($urandom));
      begin
        wait_for(3, 1'b1, 6000);
        repeat (100) @(negedge clk);
        chk("host refuses", 8'h00, hi(h_txr));
        chk("fifo filled", 8'h01, hi(nacc >= 16));
        n = 0;
        repeat (200) begin
          @(negedge clk);
          n += !txd;
        end
        chk("txd held", 8'h00, 8'(n));
        m_rxr = 1'b1;
      end
    join
    repeat (200) @(negedge clk);
    chk("cts released", 8'h00, hi(cts));
    cmp_q("modem rx", eq_m, mq);
    h_thr = 1'b1;
    repeat (10) @(negedge clk);
    chk("rts", 8'h01, hi(modem_link_if_inst.rts));
    fork
      msend(8'h5a);
      begin
        n = 0;
        repeat (150) begin
          @(negedge clk);
          n += !rxd;
        end
        chk("rxd paused", 8'h00, 8'(n));
        chk("modem refuses", 8'h00, hi(m_txr));
        h_thr = 1'b0;
      end
    join
    for (int k = 0; k < 16; k++)
      msend(k < 4 ? corner[k] : 8'($urandom));
    repeat (200) @(negedge clk);
    cmp_q("wire bits", eq_h, wq);
    cmp_q("host rx", eq_h, hq);
    msg = 1'b1;
    wait_for(4, 1'b0, 50);
    n = 0;
    while (!ri_n && n < 100) begin
      @(negedge clk);
      n++;
      if (n == 8)
        chk("host ring", 8'h01, hi(ring));
    end
    chk("ring width", 8'(RING), 8'(n));
    msg = 1'b0;
    h_rreq = 1'b1;
    @(negedge clk);
    h_rreq = 1'b0;
    wait_for(5, 1'b0, 20);
    chk("reset busy", 8'h01, hi(rbusy));
    n = 0;
    while (!rstn && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("reset width", 8'h01, hi(n >= RST));
    wait_for(2, 1'b1, 50);
    h_pwr = 1'b0;
    repeat (10) @(negedge clk);
    chk("power request", 8'h00, hi(pwr));
    chk("txd off", 8'h00, hi(txd));
    chk("running", 8'h00, hi(running));
    finish_test();
  end
endmodule
